// File: rtl/sram_pin_seq.sv
// Pin sequencer: walks one read, write or clear cycle on the memory pins.
// Assumes the top hands it one request at a time while it reports idle.
`timescale 1ns/100ps
`default_nettype none
module sram_pin_seq (
  // Clock and reset
  input  wire logic                             sys_clk_i,
  input  wire logic                             srst_i,
  // Request side
  input  wire logic                             start_i,
  input  wire logic                             wr_i,
  input  wire logic                             clr_i,
  input  wire logic [sram_host_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [sram_host_pkg::DATA_W-1:0] wdata_i,
  output logic                                  busy_o,
  output logic                                  sample_o,
  output logic                                  done_o,
  // Pins
  sram_pins_if.seq                              pins
);
  sram_host_pkg::phase_t           st_reg, st_next;
  logic [sram_host_pkg::CNT_W-1:0] cnt_reg, cnt_next;
  logic                            wr_reg, wr_next;
  logic                            done_next, sample_next;
  logic [sram_host_pkg::ADDR_W-1:0] a_next;
  logic [sram_host_pkg::DATA_W-1:0] d_next;
  logic cs1_next, cs2_next, we_next, oe_next, clr_next, dqoe_next;

  // Next phase and pin values
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    wr_next = wr_reg;
    done_next = 1'b0;
    sample_next = 1'b0;
    a_next = pins.word_address;
    d_next = pins.dq_out;
    cs1_next = pins.select_low_n;
    cs2_next = pins.select_high_pd;
    we_next = pins.write_n;
    oe_next = pins.out_en_n;
    clr_next = pins.clear_n;
    dqoe_next = pins.dq_oe;
    case (st_reg)
      sram_host_pkg::ST_IDLE: begin
        if (start_i && clr_i) begin
          clr_next = 1'b0;
          cnt_next = 4'(sram_host_pkg::CLRP_CYC - 1);
          st_next = sram_host_pkg::ST_CLR;
        end else if (start_i) begin
          a_next = addr_i; // RULE_08 RULE_09
          d_next = wdata_i;
          wr_next = wr_i;
          st_next = sram_host_pkg::ST_SETUP;
        end
      end
      sram_host_pkg::ST_SETUP: begin
        cs1_next = 1'b0; // RULE_09
        cs2_next = 1'b1; // RULE_06
        we_next = ~wr_reg; // RULE_01 RULE_02 RULE_04
        oe_next = wr_reg; // RULE_12
        dqoe_next = wr_reg;
        cnt_next = wr_reg ? 4'(sram_host_pkg::WR_CYC - 1) : 4'(sram_host_pkg::RD_CYC - 1);
        st_next = sram_host_pkg::ST_PULSE;
      end
      sram_host_pkg::ST_PULSE: begin
        if (cnt_reg == 4'h0) begin
          cs1_next = 1'b1; // RULE_03 RULE_05
          cs2_next = 1'b0; // RULE_10
          oe_next = 1'b1;
          cnt_next = 4'(sram_host_pkg::HIZ_CYC - 1);
          st_next = sram_host_pkg::ST_END;
        end else begin
          // Take read data in the last selected cycle; after deselect the lines float
          sample_next = ~wr_reg && (cnt_reg == 4'h1); // RULE_15
          cnt_next = cnt_reg - 4'h1;
        end
      end
      sram_host_pkg::ST_END: begin
        we_next = 1'b1; // RULE_05
        dqoe_next = 1'b0;
        if (cnt_reg == 4'h0) begin
          done_next = 1'b1;
          st_next = sram_host_pkg::ST_IDLE;
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      sram_host_pkg::ST_CLR: begin
        if (cnt_reg == 4'h0) begin
          clr_next = 1'b1; // RULE_13
          cnt_next = 4'(sram_host_pkg::CLRR_CYC - 1);
          st_next = sram_host_pkg::ST_CLRR;
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      sram_host_pkg::ST_CLRR: begin
        if (cnt_reg == 4'h0) begin
          done_next = 1'b1;
          st_next = sram_host_pkg::ST_IDLE;
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      default: st_next = sram_host_pkg::ST_IDLE;
    endcase
  end

  // Registers; memory deselected and powered down at reset
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      st_reg <= sram_host_pkg::ST_IDLE;
      cnt_reg <= 4'h0;
      wr_reg <= 1'b0;
      done_o <= 1'b0;
      sample_o <= 1'b0;
      pins.word_address <= 13'h0000;
      pins.dq_out <= 8'h00;
      pins.select_low_n <= 1'b1;
      pins.select_high_pd <= 1'b0;
      pins.write_n <= 1'b1;
      pins.out_en_n <= 1'b1;
      pins.clear_n <= 1'b1;
      pins.dq_oe <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      wr_reg <= wr_next;
      done_o <= done_next;
      sample_o <= sample_next;
      pins.word_address <= a_next;
      pins.dq_out <= d_next;
      pins.select_low_n <= cs1_next;
      pins.select_high_pd <= cs2_next;
      pins.write_n <= we_next;
      pins.out_en_n <= oe_next;
      pins.clear_n <= clr_next;
      pins.dq_oe <= dqoe_next;
    end
  end

  assign busy_o = (st_reg != sram_host_pkg::ST_IDLE);

  // Address may only move while deselected
  AST_ADDR_STABLE: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (!pins.select_low_n && pins.select_high_pd) |=> $stable(pins.word_address)) // RULE_08
    else $error("address moved while selected");
  // Read cycles never assert write enable
  AST_READ_NO_WE: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (!pins.out_en_n) |-> pins.write_n) // RULE_01
    else $error("write enable low during read");
  // Enables drop before write enable rises
  sequence s_wr_end;
    !pins.write_n && !pins.select_low_n ##1 pins.select_low_n;
  endsequence
  AST_WR_END: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    s_wr_end |-> !pins.write_n) // RULE_05
    else $error("write enable rose before deselect");
  // Write data stays driven across the whole write pulse
  AST_WR_DATA: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (!pins.write_n && !pins.select_low_n) |-> pins.dq_oe) // RULE_02
    else $error("data not driven in write");
  // Clear pulse is at least the least width
  AST_CLR_W: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    $fell(pins.clear_n) |-> !pins.clear_n [*3]) // RULE_13
    else $error("clear pulse short");
endmodule
`default_nettype wire

// File: inc/sram_host_pkg.sv
// Constants shared by the static memory host controller and its pin sequencer.
// Assumes a 125 MHz system clock and an 8K x 8 asynchronous memory on the pins.
package sram_host_pkg;
  // Geometry
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  // Clock period in picoseconds
  localparam int CLK_PS = 8000;
  // Cycle and pulse times, ns, slowest grade figures
  localparam int CYCLE_NS     = 35;
  localparam int WR_PULSE_NS  = 25;
  localparam int DATA_SET_NS  = 15;
  localparam int ACCESS_NS    = 35;
  localparam int HIZ_NS       = 15;
  localparam int CLR_PULSE_NS = 20;
  localparam int CLR_CYCLE_NS = 65;
  // Least times round up to whole cycles; RD_CYC takes one cycle more
  localparam int RD_CYC   = (ACCESS_NS * 1000 + CLK_PS - 1) / CLK_PS + 1;
  localparam int WR_CYC   = (WR_PULSE_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int HIZ_CYC  = (HIZ_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int CLRP_CYC = (CLR_PULSE_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int CLRR_CYC = ((CLR_CYCLE_NS - CLR_PULSE_NS) * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int CNT_W    = 4;
  // Sequencer phases, one-hot
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_SETUP = 6'h02,
    ST_PULSE = 6'h04,
    ST_END   = 6'h08,
    ST_CLR   = 6'h10,
    ST_CLRR  = 6'h20
  } phase_t;
endpackage

// File: inc/sram_pins_if.sv
// Pin-side bundle between the host top and its pin sequencer.
// Assumes one clock domain; all signals are registered in the sequencer.
`timescale 1ns/100ps
`default_nettype none
interface sram_pins_if;
  logic [sram_host_pkg::ADDR_W-1:0] word_address;
  logic                             select_low_n;
  logic                             select_high_pd;
  logic                             write_n;
  logic                             out_en_n;
  logic                             clear_n;
  logic [sram_host_pkg::DATA_W-1:0] dq_out;
  logic                             dq_oe;
  modport seq (output word_address, select_low_n, select_high_pd, write_n,
               output out_en_n, clear_n, dq_out, dq_oe);
  modport top (input word_address, select_low_n, select_high_pd, write_n,
               input out_en_n, clear_n, dq_out, dq_oe);
endinterface
`default_nettype wire

// File: rtl/sram_host.sv
// What the document says of the memory and its host
// RULE_01 - Write enable stays high throughout every read cycle.
// RULE_02 - Memory writes only while both selects and write enable are active.
// RULE_03 - Write ends when any select or write enable goes inactive.
// RULE_04 - Write enable low before selects keeps outputs high impedance. Code lowers write enable in the same cycle as the selects.
// RULE_05 - Selects drop before write enable rises, keeping outputs off.
// RULE_06 - Raising select_high_pd wakes the memory from low power.
// RULE_07 - Memory sleeps by itself after sleep_delay; host needs no action.
// RULE_08 - Address changes only while the memory is deselected.
// RULE_09 - Address valid no later than the later select asserts.
// RULE_10 - Hold select_low_n high while idle, for retention.
// RULE_11 - Memory is 8192 words of 8 bits on shared data lines.
// RULE_12 - Read: write high, selects active, output enable low.
// RULE_13 - Clear low zeroes all words; pins keep their control decode.
// RULE_14 - Sleep delay is at most 35, 25 or 20 ns per grade.
// RULE_15 - A read returns the last written byte, or zero after clear.
//
// Host controller for an 8K x 8 asynchronous static memory.
// Assumes requests are synchronous to sys_clk_i and the data pins settle in one cycle.
`timescale 1ns/100ps
`default_nettype none
module sram_host #(
  parameter int ADDR_W = sram_host_pkg::ADDR_W,
  parameter int DATA_W = sram_host_pkg::DATA_W
) (
  // Clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              srst_i,
  // User requests
  input  wire logic              req_valid_i,
  input  wire logic              req_write_i,
  input  wire logic              req_clear_i,
  input  wire logic [ADDR_W-1:0] req_addr_i,
  input  wire logic [DATA_W-1:0] req_wdata_i,
  output logic                   req_ready_o,
  output logic                   rsp_valid_o,
  output logic [DATA_W-1:0]      rsp_rdata_o,
  // Memory pins
  output logic [ADDR_W-1:0]      word_address_o,
  output logic                   select_low_n_o,
  output logic                   select_high_pd_o,
  output logic                   write_n_o,
  output logic                   out_en_n_o,
  output logic                   clear_n_o,
  input  wire logic [DATA_W-1:0] dq_i,
  output logic [DATA_W-1:0]      dq_o,
  output logic                   dq_oe_o
);
  sram_pins_if pins_bus ();
  logic              busy, sample, done;
  logic              start;
  logic              ready_next, rsp_valid_next;
  logic [DATA_W-1:0] rdata_next;

  sram_pin_seq u_seq (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .start_i   (start),
    .wr_i      (req_write_i),
    .clr_i     (req_clear_i),
    .addr_i    (req_addr_i),
    .wdata_i   (req_wdata_i),
    .busy_o    (busy),
    .sample_o  (sample),
    .done_o    (done),
    .pins      (pins_bus.seq)
  );

  // Request accepted while ready is shown
  assign start = req_valid_i && req_ready_o;

  // Handshake and read data capture
  always_comb begin
    ready_next = req_ready_o;
    rsp_valid_next = 1'b0;
    rdata_next = rsp_rdata_o;
    if (start) begin
      ready_next = 1'b0;
    end else if (done) begin
      ready_next = 1'b1;
      rsp_valid_next = 1'b1;
    end
    if (sample) begin
      rdata_next = dq_i; // RULE_15
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      req_ready_o <= 1'b1;
      rsp_valid_o <= 1'b0;
      rsp_rdata_o <= 8'h00;
    end else begin
      req_ready_o <= ready_next;
      rsp_valid_o <= rsp_valid_next;
      rsp_rdata_o <= rdata_next;
    end
  end

  // Pin registers live in the sequencer; these are straight wires from them
  assign word_address_o   = pins_bus.word_address;
  assign select_low_n_o   = pins_bus.select_low_n;
  assign select_high_pd_o = pins_bus.select_high_pd;
  assign write_n_o        = pins_bus.write_n;
  assign out_en_n_o       = pins_bus.out_en_n;
  assign clear_n_o        = pins_bus.clear_n;
  assign dq_o             = pins_bus.dq_out;
  assign dq_oe_o          = pins_bus.dq_oe;

  // Busy sequencer never shows ready
  AST_READY_BUSY: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    busy |-> !req_ready_o) // RULE_12
    else $error("ready while busy");
  // Read response follows the data sample within four cycles
  AST_RSP: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    sample |-> ##[1:4] rsp_valid_o) // RULE_15
    else $error("read response missing");
  // Deselected memory is powered down via select_high_pd
  AST_IDLE_PD: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (req_ready_o && $past(req_ready_o)) |-> (!select_high_pd_o && select_low_n_o)) // RULE_10
    else $error("memory selected while idle");
endmodule
`default_nettype wire

// File: sim/sram_dev_model.sv
// Behavioural 8K x 8 static memory with flash clear and self timed sleep.
// Assumes the host drives every control pin; the data wire level is resolved here.
`timescale 1ns/100ps
`default_nettype none
module sram_dev_model #(
  parameter int ACC_NS   = 35,
  parameter int SLEEP_NS = 35
) (
  // Memory pins
  input  wire logic [12:0] word_address,
  input  wire logic        select_low_n,
  input  wire logic        select_high_pd,
  input  wire logic        write_n,
  input  wire logic        out_en_n,
  input  wire logic        clear_n,
  input  wire logic [7:0]  host_dq,
  input  wire logic        host_oe,
  // Resolved data lines and status
  output logic [7:0]       dq_wire,
  output logic             awake,
  output int               viol_count
);
  logic [7:0] mem [0:8191];
  logic [7:0] junk;
  logic       rd_ok;
  realtime    wake_t;
  wire sel = !select_low_n && select_high_pd;
  wire wr  = sel && !write_n;
  wire rd  = sel && write_n && !out_en_n;
  initial begin
    junk = 8'h5A;
    awake = 1'b0;
    viol_count = 0;
    wake_t = 0;
    rd_ok = 1'b0;
  end
  // Undriven lines show a moving pattern, never the last value
  always #4 junk = junk + 8'h3B;
  // Read data only appears once the access time has run
  always @(rd) begin
    rd_ok = 1'b0;
    if (rd) #ACC_NS rd_ok = rd;
  end
  assign dq_wire = rd_ok ? mem[word_address] : (host_oe ? host_dq : junk);
  // Store while the overlap of both selects and write enable lasts
  always @* if (wr && clear_n) mem[word_address] = dq_wire;
  always @(negedge clear_n) for (int i = 0; i < 8192; i++) mem[i] = 8'h00;
  // Both sides driving the data lines at once
  always @(posedge rd, posedge host_oe) if (rd && host_oe) viol_count++;
  task automatic wake();
    awake = 1'b1;
    wake_t = $realtime;
  endtask
  // Wake events, and pin misuse by the host
  always @(posedge select_high_pd) wake();
  always @(word_address) if (sel) begin
    wake();
    viol_count++;
  end
  always @(negedge write_n) if (sel) begin
    wake();
    if (!out_en_n) viol_count++;
  end
  always @(host_dq) if (wr) wake();
  always #1 if (awake && $realtime - wake_t >= SLEEP_NS) awake = 1'b0;
endmodule
`default_nettype wire

// File: sim/async_sram_access_powerdown_bench.sv
// Self-checking bench for the static memory host controller.
// Assumes the behavioural memory model on the pins and one 125 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module async_sram_access_powerdown_bench;
  logic        sys_clk_i, srst_i, req_valid_i, req_write_i, req_clear_i;
  logic [12:0] req_addr_i, word_address_o;
  logic [7:0]  req_wdata_i, rsp_rdata_o, dq_i, dq_o;
  logic        req_ready_o, rsp_valid_o, select_low_n_o, select_high_pd_o;
  logic        write_n_o, out_en_n_o, clear_n_o, dq_oe_o, awake, saw_awake;
  int          viol_count, fail_count, cmp_count;
  sram_host dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .req_valid_i(req_valid_i),
    .req_write_i(req_write_i), .req_clear_i(req_clear_i), .req_addr_i(req_addr_i),
    .req_wdata_i(req_wdata_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
    .rsp_rdata_o(rsp_rdata_o), .word_address_o(word_address_o),
    .select_low_n_o(select_low_n_o), .select_high_pd_o(select_high_pd_o),
    .write_n_o(write_n_o), .out_en_n_o(out_en_n_o), .clear_n_o(clear_n_o),
    .dq_i(dq_i), .dq_o(dq_o), .dq_oe_o(dq_oe_o));
  sram_dev_model mem (.word_address(word_address_o), .select_low_n(select_low_n_o),
    .select_high_pd(select_high_pd_o), .write_n(write_n_o), .out_en_n(out_en_n_o),
    .clear_n(clear_n_o), .host_dq(dq_o), .host_oe(dq_oe_o), .dq_wire(dq_i),
    .awake(awake), .viol_count(viol_count));
  // Clock
  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  // Remember that the memory was woken at least once
  always @(posedge sys_clk_i) if (awake === 1'b1) saw_awake <= 1'b1;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One request, bounded waits, latency and read data judged
  task automatic do_op(input logic c, input logic w, input logic [12:0] a,
                       input logic [7:0] d, input logic [7:0] exp);
    int n;
    int lat;
    n = 0;
    lat = (w && !c) ? 8 : 10;
    while (req_ready_o !== 1'b1 && n < 40) begin @(posedge sys_clk_i); #1; n++; end
    req_valid_i = 1'b1;
    req_clear_i = c;
    req_write_i = w;
    req_addr_i = a;
    req_wdata_i = d;
    @(posedge sys_clk_i);
    #1;
    req_valid_i = 1'b0;
    n = 0;
    while (rsp_valid_o !== 1'b1 && n < 40) begin @(posedge sys_clk_i); #1; n++; end
    chk({15'h0000, n >= lat - 1 && n <= lat + 1}, 16'h0001);
    chk({15'h0000, req_ready_o}, 16'h0001);
    if (!w && !c) chk({8'h00, rsp_rdata_o}, {8'h00, exp});
  endtask
  // Idle pins leave the memory deselected and powered down
  task automatic t_idle();
    chk({10'h000, select_low_n_o, select_high_pd_o, write_n_o, out_en_n_o, clear_n_o,
         dq_oe_o}, 16'h002E);
  endtask
  // Back to back writes then reads at the address extremes
  task automatic t_rw();
    logic [12:0] adr [4];
    logic [7:0]  dat [4];
    adr = '{13'h0000, 13'h1FFF, 13'h0AAA, 13'h1555};
    dat = '{8'hA5, 8'h5A, 8'hFF, 8'h00};
    for (int i = 0; i < 4; i++) do_op(1'b0, 1'b1, adr[i], dat[i], 8'h00);
    for (int i = 0; i < 4; i++) do_op(1'b0, 1'b0, adr[i], 8'h00, dat[i]);
  endtask
  // Overwrite, flash clear, then a write that follows the clear
  task automatic t_clear();
    do_op(1'b0, 1'b1, 13'h0007, 8'h11, 8'h00);
    do_op(1'b0, 1'b1, 13'h0007, 8'h22, 8'h00);
    do_op(1'b0, 1'b0, 13'h0007, 8'h00, 8'h22);
    do_op(1'b1, 1'b0, 13'h0000, 8'h00, 8'h00);
    do_op(1'b0, 1'b0, 13'h0007, 8'h00, 8'h00);
    do_op(1'b0, 1'b0, 13'h1FFF, 8'h00, 8'h00);
    do_op(1'b0, 1'b1, 13'h0007, 8'h33, 8'h00);
    do_op(1'b0, 1'b0, 13'h0007, 8'h00, 8'h33);
  endtask
  // Memory slept again and the host kept its pin discipline
  task automatic t_power();
    repeat (10) @(posedge sys_clk_i);
    #1;
    chk({15'h0000, awake}, 16'h0000);
    chk({15'h0000, saw_awake}, 16'h0001);
    chk(16'(viol_count), 16'h0000);
    t_idle();
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    srst_i = 1'b1;
    req_valid_i = 1'b0;
    req_write_i = 1'b0;
    req_clear_i = 1'b0;
    req_addr_i = 13'h0000;
    req_wdata_i = 8'h00;
    saw_awake = 1'b0;
    fail_count = 0;
    cmp_count = 0;
    repeat (3) @(posedge sys_clk_i);
    #1;
    srst_i = 1'b0;
    t_idle();
    t_rw();
    t_clear();
    t_power();
    wrap_up();
  end
  // Watchdog
  initial begin
    #50000;
    fail_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
